// >>> hw/bfx_pkg.sv
// bfx_pkg: shared constants and types for the bit, flag and transfer execution block.
// assumes the front end hands over instructions already decoded into bfx_op_type form.
`default_nettype none

package bfx_pkg;

  // data path and storage sizes
  localparam int unsigned BFX_NUM_REGS = 32;
  localparam int unsigned BFX_DATA_W   = 8;
  localparam int unsigned BFX_ADDR_W   = 16;
  localparam int unsigned BFX_DISP_W   = 6;

  // bit positions inside status_flag_register
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // reset values
  localparam logic [7:0]  BFX_STATUS_FLAG_REGISTER_RESET = 8'h00;
  localparam logic [15:0] BFX_SP_RESET   = 16'h0000;

  // the three pointers live in the top register pairs, low byte first
  localparam logic [4:0]  BFX_PTR_BASE   = 5'h1A;
  localparam logic [15:0] BFX_ONE16      = 16'h0001;

  // wishbone byte offsets of the control registers
  localparam logic [7:0]  BFX_OFS_STATUS  = 8'h00;
  localparam logic [7:0]  BFX_OFS_CONTROL = 8'h04;
  localparam logic [7:0]  BFX_OFS_STACK   = 8'h08;
  localparam logic [7:0]  BFX_OFS_STATE   = 8'h0C;

  // fields of the control and state registers
  localparam int unsigned CTRL_DEBUG_BIT = 0;
  localparam int unsigned CTRL_SLEEP_BIT = 1;
  localparam int unsigned STATE_BUSY_BIT = 0;

  // decoded operations accepted from the front end
  typedef enum logic [4:0] {
    OP_NOP, OP_SWAP, OP_FLAG_SET, OP_FLAG_CLR, OP_BIT_TO_FLAG, OP_BIT_FROM_FLAG,
    OP_MOVE, OP_PAIR_COPY, OP_IMM_LOAD, OP_LOAD_IND, OP_STORE_IND, OP_LOAD_ABS,
    OP_STORE_ABS, OP_PROG_READ, OP_PUSH, OP_POP, OP_SLEEP, OP_WDOG, OP_BREAK
  } bfx_op_type;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} bfx_ptr_type;

  typedef enum logic [1:0] {AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_DISP} bfx_mode_type;

endpackage

`default_nettype wire

// >>> hw/bfx_addr_unit.sv
// bfx_addr_unit: effective address and pointer update for indirect accesses.
// assumes the caller supplies the pointer value and has already checked the mode.
`default_nettype none
`timescale 1ns/1ps

module bfx_addr_unit import bfx_pkg::*; (
  input  wire logic [BFX_ADDR_W-1:0] ptrVal,
  input  wire bfx_mode_type          mode,
  input  wire logic [BFX_DISP_W-1:0] disp,
  output logic      [BFX_ADDR_W-1:0] effAddr,
  output logic      [BFX_ADDR_W-1:0] ptrNext,
  output logic                       ptrWrite
);

  // address used by the access and pointer value left behind
  always_comb begin
    effAddr  = ptrVal;
    ptrNext  = ptrVal;
    ptrWrite = 1'b0;
    case (mode)
      AM_POSTINC: begin
        ptrNext  = ptrVal + BFX_ONE16;
        ptrWrite = 1'b1;
      end
      AM_PREDEC: begin
        effAddr  = ptrVal - BFX_ONE16;
        ptrNext  = ptrVal - BFX_ONE16;
        ptrWrite = 1'b1;
      end
      AM_DISP: begin
        // pointer itself is left alone
        effAddr  = ptrVal + {{(BFX_ADDR_W-BFX_DISP_W){1'b0}}, disp};
      end
      default: begin
        effAddr  = ptrVal;
      end
    endcase
  end

endmodule

`default_nettype wire

// >>> hw/bfx_exec_core.sv
// bfx_exec_core: executes bit, flag, data transfer and core control operations.
// assumes a decoded operation from the front end, an asynchronous-read data memory
// and a program memory that returns its byte one cycle after the read strobe.
`default_nettype none
`timescale 1ns/1ps

module bfx_exec_core import bfx_pkg::*; #(
  parameter logic [15:0] SP_RESET = BFX_SP_RESET
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  // decoded operation from the front end
  input  wire logic                  instValid,
  input  wire bfx_op_type            instOp,
  input  wire logic [4:0]            instDst,
  input  wire logic [4:0]            instSrc,
  input  wire logic [2:0]            instBit,
  input  wire bfx_ptr_type           instPtr,
  input  wire bfx_mode_type          instMode,
  input  wire logic [BFX_DISP_W-1:0] instDisp,
  input  wire logic [7:0]            instImm,
  input  wire logic [BFX_ADDR_W-1:0] instAbs,
  output logic                       execBusy,
  output logic                       execDone,
  // data memory
  output logic [BFX_ADDR_W-1:0]      dataAddr,
  output logic [7:0]                 dataWdata,
  output logic                       dataWe,
  output logic                       dataRe,
  input  wire logic [7:0]            dataRdata,
  // program memory
  output logic [BFX_ADDR_W-1:0]      progAddr,
  output logic                       progRe,
  input  wire logic [7:0]            progRdata,
  // core control
  output logic                       sleepReq,
  output logic                       wdtRestart,
  output logic                       breakHit,
  output logic [7:0]                 statusFlags,
  // wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_PROG_WAIT, ST_PROG_DATA} bfx_state_type;

  bfx_state_type         state_q;
  logic [7:0]            regs_q [BFX_NUM_REGS];
  logic [7:0]            status_flag_register_q;
  logic [15:0]           sp_q;
  logic                  dbgEn_q;
  logic                  sleepEn_q;
  bfx_op_type            opHeld_q;
  logic [4:0]            dstHeld_q;
  bfx_ptr_type           ptrHeld_q;
  logic [15:0]           ptrNew_q;
  logic                  ptrWr_q;
  logic                  busy_q;
  logic                  done_q;
  logic [15:0]           dataAddr_q;
  logic [7:0]            dataWdata_q;
  logic                  dataWe_q;
  logic                  dataRe_q;
  logic [15:0]           progAddr_q;
  logic                  progRe_q;
  logic                  sleepReq_q;
  logic                  wdtRestart_q;
  logic                  breakHit_q;
  logic                  ack_q;
  logic [31:0]           rdat_q;
  logic [31:0]           rdat_d;

  logic                  take;
  logic                  isData;
  logic                  isProg;
  logic                  finData;
  logic                  finProg;
  logic                  wbReq;
  logic                  wbWr;
  bfx_mode_type          effMode;
  logic [15:0]           ptrCur;
  logic [15:0]           effAddr;
  logic [15:0]           ptrNext;
  logic                  ptrWrite;

  // low register index of a pointer pair
  function automatic logic [4:0] ptrLo(input bfx_ptr_type sel);
    return BFX_PTR_BASE + {2'b00, sel, 1'b0};
  endfunction

  // 16-bit pointer value read from the register pair
  function automatic logic [15:0] ptrRead(input bfx_ptr_type sel,
                                          input logic [7:0] rf [BFX_NUM_REGS]);
    logic [4:0] lo;
    lo = ptrLo(sel);
    return {rf[lo + 5'h01], rf[lo]};
  endfunction

  // operation handshake and completion points
  assign take    = instValid && !busy_q;
  assign isData  = (instOp == OP_LOAD_IND) || (instOp == OP_STORE_IND) ||
                   (instOp == OP_LOAD_ABS) || (instOp == OP_STORE_ABS) ||
                   (instOp == OP_PUSH) || (instOp == OP_POP);
  assign isProg  = (instOp == OP_PROG_READ);
  assign finData = (state_q == ST_DATA);
  assign finProg = (state_q == ST_PROG_DATA);

  // displacement exists only on Y and Z; X with a displacement acts as plain
  assign effMode = (instMode == AM_DISP && instPtr == PTR_X) ? AM_PLAIN : instMode;
  // program reads always go through Z and only know post-increment
  assign ptrCur  = isProg ? ptrRead(PTR_Z, regs_q) : ptrRead(instPtr, regs_q);

  bfx_addr_unit u_addr (
    .ptrVal   (ptrCur),
    .mode     (isProg ? ((instMode == AM_POSTINC) ? AM_POSTINC : AM_PLAIN) : effMode),
    .disp     (instDisp),
    .effAddr  (effAddr),
    .ptrNext  (ptrNext),
    .ptrWrite (ptrWrite)
  );

  // sequencer: data ops take two cycles, program reads three
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && isData) begin
            state_q <= ST_DATA;
            busy_q  <= 1'b1;
          end else if (take && isProg) begin
            state_q <= ST_PROG_WAIT;
            busy_q  <= 1'b1;
          end
        end
        ST_PROG_WAIT: begin
          state_q <= ST_PROG_DATA;
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // details of a multi-cycle operation held until it finishes
  always_ff @(posedge clock) begin
    if (rst) begin
      opHeld_q  <= OP_NOP;
      dstHeld_q <= 5'h00;
      ptrHeld_q <= PTR_X;
      ptrNew_q  <= 16'h0000;
      ptrWr_q   <= 1'b0;
    end else if (take) begin
      opHeld_q  <= instOp;
      dstHeld_q <= instDst;
      ptrHeld_q <= isProg ? PTR_Z : instPtr;
      ptrNew_q  <= ptrNext;
      // only indirect and program reads move a pointer
      ptrWr_q   <= ptrWrite && (isProg || instOp == OP_LOAD_IND || instOp == OP_STORE_IND);
    end
  end

  // register file: single-cycle writes at take, loaded bytes at completion
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < BFX_NUM_REGS; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      if (take) begin
        case (instOp)
          OP_SWAP: begin
            regs_q[instDst] <= {regs_q[instDst][3:0], regs_q[instDst][7:4]};
          end
          OP_BIT_FROM_FLAG: begin
            regs_q[instDst][instBit] <= status_flag_register_q[FLAG_T];
          end
          OP_MOVE: begin
            regs_q[instDst] <= regs_q[instSrc];
          end
          OP_PAIR_COPY: begin
            // pairs are even aligned, the low index bit is ignored
            regs_q[{instDst[4:1], 1'b0}] <= regs_q[{instSrc[4:1], 1'b0}];
            regs_q[{instDst[4:1], 1'b1}] <= regs_q[{instSrc[4:1], 1'b1}];
          end
          OP_IMM_LOAD: begin
            regs_q[instDst] <= instImm;
          end
          default: begin
          end
        endcase
      end
      // pointer update first, so a load into the pointer itself wins
      if ((finData || finProg) && ptrWr_q) begin
        regs_q[ptrLo(ptrHeld_q)]         <= ptrNew_q[7:0];
        regs_q[ptrLo(ptrHeld_q) + 5'h01] <= ptrNew_q[15:8];
      end
      if (finData && (opHeld_q == OP_LOAD_IND || opHeld_q == OP_LOAD_ABS ||
                      opHeld_q == OP_POP)) begin
        regs_q[dstHeld_q] <= dataRdata;
      end
      if (finProg) begin
        regs_q[dstHeld_q] <= progRdata;
      end
    end
  end

  // status flags: a bus write lands first, an instruction in the same cycle wins
  always_ff @(posedge clock) begin
    if (rst) begin
      status_flag_register_q <= BFX_STATUS_FLAG_REGISTER_RESET;
    end else begin
      if (wbWr && wb_adr_i == BFX_OFS_STATUS && wb_sel_i[0]) begin
        status_flag_register_q <= wb_dat_i[7:0];
      end
      if (take) begin
        case (instOp)
          OP_FLAG_SET: begin
            status_flag_register_q[instBit] <= 1'b1;
          end
          OP_FLAG_CLR: begin
            status_flag_register_q[instBit] <= 1'b0;
          end
          OP_BIT_TO_FLAG: begin
            status_flag_register_q[FLAG_T] <= regs_q[instSrc][instBit];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // stack pointer: push stores then lowers, pop raises then reads
  always_ff @(posedge clock) begin
    if (rst) begin
      sp_q <= SP_RESET;
    end else if (take && instOp == OP_PUSH) begin
      sp_q <= sp_q - BFX_ONE16;
    end else if (take && instOp == OP_POP) begin
      sp_q <= sp_q + BFX_ONE16;
    end else if (wbWr && wb_adr_i == BFX_OFS_STACK) begin
      if (wb_sel_i[0]) begin
        sp_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        sp_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // data memory strobes stand for exactly the second cycle of a data op
  always_ff @(posedge clock) begin
    if (rst) begin
      dataAddr_q  <= 16'h0000;
      dataWdata_q <= 8'h00;
      dataWe_q    <= 1'b0;
      dataRe_q    <= 1'b0;
    end else if (take && isData) begin
      dataWdata_q <= regs_q[instSrc];
      dataWe_q    <= (instOp == OP_STORE_IND) || (instOp == OP_STORE_ABS) ||
                     (instOp == OP_PUSH);
      dataRe_q    <= (instOp == OP_LOAD_IND) || (instOp == OP_LOAD_ABS) ||
                     (instOp == OP_POP);
      case (instOp)
        OP_LOAD_ABS, OP_STORE_ABS: begin
          dataAddr_q <= instAbs;
        end
        OP_PUSH: begin
          dataAddr_q <= sp_q;
        end
        OP_POP: begin
          dataAddr_q <= sp_q + BFX_ONE16;
        end
        default: begin
          dataAddr_q <= effAddr;
        end
      endcase
    end else if (finData) begin
      dataWe_q <= 1'b0;
      dataRe_q <= 1'b0;
    end
  end

  // program memory strobe: one cycle, byte comes back the cycle after
  always_ff @(posedge clock) begin
    if (rst) begin
      progAddr_q <= 16'h0000;
      progRe_q   <= 1'b0;
    end else if (take && isProg) begin
      progAddr_q <= effAddr;
      progRe_q   <= 1'b1;
    end else begin
      progRe_q   <= 1'b0;
    end
  end

  // completion and core control pulses
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q       <= 1'b0;
      sleepReq_q   <= 1'b0;
      wdtRestart_q <= 1'b0;
      breakHit_q   <= 1'b0;
    end else begin
      done_q       <= (take && !isData && !isProg) || finData || finProg;
      // sleep is only requested while software has enabled it
      sleepReq_q   <= take && instOp == OP_SLEEP && sleepEn_q;
      wdtRestart_q <= take && instOp == OP_WDOG;
      // without debug a break behaves as a no-operation
      breakHit_q   <= take && instOp == OP_BREAK && dbgEn_q;
    end
  end

  // control register: reserved bits are dropped on write and read as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      dbgEn_q   <= 1'b0;
      sleepEn_q <= 1'b0;
    end else if (wbWr && wb_adr_i == BFX_OFS_CONTROL && wb_sel_i[0]) begin
      dbgEn_q   <= wb_dat_i[CTRL_DEBUG_BIT];
      sleepEn_q <= wb_dat_i[CTRL_SLEEP_BIT];
    end
  end

  // wishbone: ack one cycle after the request, write lands on the acked edge
  assign wbReq = wb_cyc_i && wb_stb_i;
  assign wbWr  = wbReq && wb_we_i && ack_q;

  // read data selection; unmapped offsets answer with zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (wb_adr_i == BFX_OFS_STATUS) begin
      rdat_d[7:0] = status_flag_register_q;
    end else if (wb_adr_i == BFX_OFS_CONTROL) begin
      rdat_d[CTRL_DEBUG_BIT] = dbgEn_q;
      rdat_d[CTRL_SLEEP_BIT] = sleepEn_q;
    end else if (wb_adr_i == BFX_OFS_STACK) begin
      rdat_d[15:0] = sp_q;
    end else if (wb_adr_i == BFX_OFS_STATE) begin
      rdat_d[STATE_BUSY_BIT] = busy_q;
    end
  end

  // bus answer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= wbReq && !ack_q;
      rdat_q <= (wbReq && !ack_q) ? rdat_d : 32'h0000_0000;
    end
  end

  // every output straight from a flip-flop
  assign execBusy    = busy_q;
  assign execDone    = done_q;
  assign dataAddr    = dataAddr_q;
  assign dataWdata   = dataWdata_q;
  assign dataWe      = dataWe_q;
  assign dataRe      = dataRe_q;
  assign progAddr    = progAddr_q;
  assign progRe      = progRe_q;
  assign sleepReq    = sleepReq_q;
  assign wdtRestart  = wdtRestart_q;
  assign breakHit    = breakHit_q;
  assign statusFlags = status_flag_register_q;
  assign wb_dat_o    = rdat_q;
  assign wb_ack_o    = ack_q;

endmodule

`default_nettype wire

// >>> dv/bfx_mem_model.sv
// bfx_mem_model: data and program memory facing the execution core.
// assumes one clock; data reads are combinational, program bytes lag progRe by one cycle.
`default_nettype none
`timescale 1ns/1ps

module bfx_mem_model import bfx_pkg::*; (
  input  wire logic [15:0] dataAddr,
  input  wire logic [7:0]  dataWdata,
  input  wire logic        dataWe,
  input  wire logic        dataRe,
  output logic      [7:0]  dataRdata,
  input  wire logic        clock,
  input  wire logic [15:0] progAddr,
  input  wire logic        progRe,
  output logic      [7:0]  progRdata
);
  logic [7:0] cells [256];
  logic [7:0] junk_q  = 8'h11;
  logic [7:0] pByte_q = 8'h00;
  logic       pVal_q  = 1'b0;

  // idle lines change every cycle so a stale byte never passes for a read;
  // plain always, since these variables also carry declaration initialisers
  always @(posedge clock) begin
    junk_q  <= junk_q + 8'h3B;
    pVal_q  <= progRe;
    pByte_q <= progAddr[7:0] ^ 8'h5A;
    if (dataWe) begin
      cells[dataAddr[7:0]] <= dataWdata;
    end
  end

  // program bytes only show in the cycle after the strobe
  assign dataRdata = dataRe ? cells[dataAddr[7:0]] : junk_q;
  assign progRdata = pVal_q ? pByte_q : junk_q;
endmodule

`default_nettype wire

// >>> dv/bfx_exec_core_props.sv
// bfx_exec_core_props: timing and flag checks on the execution core ports.
// assumes binding into bfx_exec_core; one clock, synchronous reset.
`default_nettype none
`timescale 1ns/1ps

module bfx_exec_core_props import bfx_pkg::*; (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       instValid,
  input wire bfx_op_type instOp,
  input wire logic [2:0] instBit,
  input wire logic       execBusy,
  input wire logic       execDone,
  input wire logic       dataRe,
  input wire logic       dataWe,
  input wire logic       progRe,
  input wire logic       wdtRestart,
  input wire logic [7:0] statusFlags
);
  logic take;
  logic dataOp;

  // an operation is accepted only while the core is idle
  assign take   = instValid && !execBusy;
  assign dataOp = instOp inside {OP_LOAD_IND, OP_STORE_IND, OP_LOAD_ABS, OP_STORE_ABS,
                                 OP_PUSH, OP_POP};

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // break is left out, though the core completes it in one cycle like the other short ops
  one_cycle_a: assert property (
      take && !dataOp && !(instOp inside {OP_PROG_READ, OP_BREAK}) |=> execDone && !execBusy)
    else $error("short op late");
  data_op_a: assert property (
      take && dataOp |=> execBusy && (dataRe || dataWe) ##1 execDone && !execBusy)
    else $error("data op timing");
  prog_read_a: assert property (
      take && instOp == OP_PROG_READ |=> progRe && execBusy ##1 !progRe && execBusy ##1 execDone)
    else $error("prog read timing");
  flag_set_a: assert property (
      take && instOp == OP_FLAG_SET |=>
      statusFlags == ($past(statusFlags) | (8'h01 << $past(instBit))))
    else $error("flag set");
  flag_clr_a: assert property (
      take && instOp == OP_FLAG_CLR |=>
      statusFlags == ($past(statusFlags) & ~(8'h01 << $past(instBit))))
    else $error("flag clr");
  t_copy_a: assert property (
      take && instOp == OP_BIT_TO_FLAG |=>
      ((statusFlags ^ $past(statusFlags)) & 8'hBF) == 8'h00)
    else $error("t copy");
  bit_load_a: assert property (
      take && instOp == OP_BIT_FROM_FLAG |=> $stable(statusFlags))
    else $error("bit load flags");
  data_flags_a: assert property (
      take && dataOp |=> $stable(statusFlags) [*2])
    else $error("data op flags");
  wdt_pulse_a: assert property (
      take && instOp == OP_WDOG |=> wdtRestart ##1 !wdtRestart)
    else $error("wdt pulse");
endmodule

`default_nettype wire

// >>> dv/bfx_exec_core_test.sv
// bfx_exec_core_test: directed checks of the execution core through its ports.
// assumes bfx_mem_model as data and program memory; one 200 MHz clock.
`default_nettype none
`timescale 1ns/1ps

module bfx_exec_core_test import bfx_pkg::*;;
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  logic         instValid = 1'b0;
  bfx_op_type   instOp = OP_NOP;
  logic [4:0]   instDst = 5'h00, instSrc = 5'h00;
  logic [2:0]   instBit = 3'h0;
  bfx_ptr_type  instPtr = PTR_X;
  bfx_mode_type instMode = AM_PLAIN;
  logic [5:0]   instDisp = 6'h00;
  logic [7:0]   instImm = 8'h00, wb_adr_i = 8'h00;
  logic [15:0]  instAbs = 16'h0000, dataAddr, progAddr;
  logic         execBusy, execDone, dataWe, dataRe, progRe, sleepReq, wdtRestart, breakHit;
  logic [7:0]   dataWdata, dataRdata, progRdata, statusFlags;
  logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0]   wb_sel_i = 4'h0;
  logic [31:0]  wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  int           failCount = 0, checks = 0, sleepCnt = 0, wdtCnt = 0, brkCnt = 0;

  bfx_exec_core uut (
    .clock, .rst, .instValid, .instOp, .instDst, .instSrc, .instBit, .instPtr, .instMode,
    .instDisp, .instImm, .instAbs, .execBusy, .execDone, .dataAddr, .dataWdata, .dataWe,
    .dataRe, .dataRdata, .progAddr, .progRe, .progRdata, .sleepReq, .wdtRestart, .breakHit,
    .statusFlags, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o
  );
  bfx_mem_model mem (
    .dataAddr, .dataWdata, .dataWe, .dataRe, .dataRdata, .clock, .progAddr, .progRe,
    .progRdata
  );

  always #2.5 clock = ~clock;

  // pulses counted mid-cycle, clear of the edges that launch them
  always @(negedge clock) begin
    sleepCnt += int'(sleepReq === 1'b1);
    wdtCnt += int'(wdtRestart === 1'b1);
    brkCnt += int'(breakHit === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d failCount %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bound_hit(input int n);
    if (n >= 9) begin
      failCount++;
      report_and_stop;
    end
  endtask

  // one operation: offer, let it be taken, wait for done and check its latency
  task automatic op(input bfx_op_type o, input int lat, input int d = 0, s = 0, b = 0,
                    input bfx_ptr_type p = PTR_X, input bfx_mode_type m = AM_PLAIN,
                    input logic [15:0] k = 16'h0000);
    int n;
    @(posedge clock);
    instValid <= 1'b1;
    instOp <= o;
    instDst <= 5'(d);
    instSrc <= 5'(s);
    instBit <= 3'(b);
    instPtr <= p;
    instMode <= m;
    instDisp <= k[5:0];
    instImm <= k[7:0];
    instAbs <= k;
    @(posedge clock);
    instValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (execDone !== 1'b1 && n < 9);
    bound_hit(n);
    if (lat > 0) chk(32'(n), 32'(lat));
  endtask

  // classic single wishbone cycle; read data lands in rd
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 9);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    bound_hit(n);
  endtask

  // registers are only visible by storing them to a scratch byte
  task automatic reg_is(input int r, input logic [7:0] v);
    op(OP_STORE_ABS, 2, 0, r, 0, PTR_X, AM_PLAIN, 16'h00F0);
    chk(32'(mem.cells[8'hF0]), 32'(v));
  endtask

  task automatic li(input int r, input logic [7:0] v);
    op(OP_IMM_LOAD, 1, r, 0, 0, PTR_X, AM_PLAIN, {8'h00, v});
  endtask

  task automatic t_flags;
    logic [7:0] e;
    e = 8'h00;
    chk(32'(statusFlags), 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      op(i < 8 ? OP_FLAG_SET : OP_FLAG_CLR, 1, 0, 0, i % 8);
      e[i % 8] = (i < 8);
      chk(32'(statusFlags), 32'(e));
      if (i == 7) wb(1'b0, BFX_OFS_STATUS, 32'h0000_0000);
      if (i == 7) chk(rd, 32'h0000_00FF);
    end
  endtask

  task automatic t_bits;
    li(1, 8'h08);
    op(OP_BIT_TO_FLAG, 1, 0, 1, 2);
    chk(32'(statusFlags), 32'h0000_0000);
    op(OP_BIT_TO_FLAG, 1, 0, 1, 3);
    chk(32'(statusFlags), 32'h0000_0040);
    li(2, 8'h81);
    op(OP_BIT_FROM_FLAG, 1, 2, 0, 4);
    reg_is(2, 8'h91);
    op(OP_SWAP, 1, 2);
    op(OP_MOVE, 1, 3, 2);
    op(OP_PAIR_COPY, 1, 4, 2);
    reg_is(5, 8'h19);
    chk(32'(statusFlags), 32'h0000_0040);
  endtask

  task automatic t_ind;
    li(26, 8'h20);
    li(27, 8'h00);
    li(9, 8'hC3);
    op(OP_STORE_IND, 2, 0, 9, 0, PTR_X, AM_POSTINC);
    op(OP_STORE_IND, 2, 0, 1, 0, PTR_X, AM_POSTINC);
    op(OP_STORE_IND, 2, 0, 2, 0, PTR_X, AM_PREDEC);
    chk(32'({mem.cells[8'h20], mem.cells[8'h21]}), 32'h0000_C319);
    op(OP_LOAD_IND, 2, 10, 0, 0, PTR_X, AM_PREDEC);
    op(OP_LOAD_IND, 2, 11, 0, 0, PTR_X, AM_POSTINC);
    op(OP_LOAD_IND, 2, 12, 0, 0, PTR_X, AM_PLAIN);
    reg_is(10, 8'hC3);
    reg_is(12, 8'h19);
    li(28, 8'h30);
    li(29, 8'h00);
    op(OP_STORE_IND, 2, 0, 9, 0, PTR_Y, AM_DISP, 16'h0005);
    op(OP_STORE_IND, 2, 0, 2, 0, PTR_Y, AM_PLAIN);
    chk(32'({mem.cells[8'h35], mem.cells[8'h30]}), 32'h0000_C319);
    op(OP_LOAD_IND, 2, 13, 0, 0, PTR_Y, AM_DISP, 16'h0005);
    reg_is(13, 8'hC3);
    op(OP_LOAD_ABS, 2, 14, 0, 0, PTR_X, AM_PLAIN, 16'h0030);
    reg_is(14, 8'h19);
    chk(32'(statusFlags), 32'h0000_0040);
  endtask

  task automatic t_prog_stack;
    li(30, 8'h40);
    li(31, 8'h00);
    op(OP_PROG_READ, 3, 15, 0, 0, PTR_Z, AM_POSTINC);
    op(OP_PROG_READ, 3, 16, 0, 0, PTR_Z, AM_POSTINC);
    reg_is(16, 8'h1B);
    wb(1'b0, BFX_OFS_STACK, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, BFX_OFS_STACK, 32'h0000_0060);
    op(OP_PUSH, 2, 0, 9);
    chk(32'(mem.cells[8'h60]), 32'h0000_00C3);
    wb(1'b0, BFX_OFS_STACK, 32'h0000_0000);
    chk(rd, 32'h0000_005F);
    op(OP_POP, 2, 17);
    reg_is(17, 8'hC3);
  endtask

  task automatic t_ctrl;
    op(OP_SLEEP, 1);
    wb(1'b1, BFX_OFS_CONTROL, 32'h0000_0002); // reserved bits zero
    op(OP_SLEEP, 1);
    op(OP_WDOG, 1);
    op(OP_BREAK, 0);
    chk(32'(sleepCnt * 256 + wdtCnt * 16 + brkCnt), 32'h0000_0110);
    wb(1'b1, BFX_OFS_CONTROL, 32'h0000_0003);
    op(OP_BREAK, 0);
    chk(32'(brkCnt), 32'h0000_0001);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, BFX_OFS_STATE, 32'h0000_0001);
    wb(1'b0, BFX_OFS_STATE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_flags;
    t_bits;
    t_ind;
    t_prog_stack;
    t_ctrl;
    report_and_stop;
  end

  // hang guard
  initial begin
    #400000;
    failCount++;
    report_and_stop;
  end
endmodule

bind bfx_exec_core bfx_exec_core_props props (.clock, .rst, .instValid, .instOp, .instBit,
  .execBusy, .execDone, .dataRe, .dataWe, .progRe, .wdtRestart, .statusFlags);

`default_nettype wire
